// file: pwm_protection_sequencer_regs.svh
`ifndef PWM_PROTECTION_SEQUENCER_REGS_SVH
`define PWM_PROTECTION_SEQUENCER_REGS_SVH

// Register byte offsets
`define REG_CTRL        8'h00
`define REG_IRQ_STATUS  8'h04
`define REG_IRQ_MASK    8'h08
`define REG_STATE       8'h0C

// Control fields and reset values
`define CTRL_DITHER_BIT 0
`define CTRL_RESET      1'h1
`define IRQ_MASK_RESET  6'h00

// Event bit positions, shared by status and mask
`define EV_OCP          0
`define EV_BURST        1
`define EV_OVERLOAD     2
`define EV_OVERVOLT     3
`define EV_THERMAL      4
`define EV_BIAS         5
`define EV_WIDTH        6

// Synchronised input positions
`define IN_FB_TRIP      0
`define IN_OCP_TRIP     1
`define IN_FB_STOP      2
`define IN_OLP_HIGH     3
`define IN_SUPPLY_ON    4
`define IN_SUPPLY_OFF   5
`define IN_BIAS_LOW     6
`define IN_OVERVOLT     7
`define IN_HOT          8
`define IN_LATCH_SEL    9
`define IN_WIDTH        10

// Timing
`define CLK_MHZ         250
`define BLANK_TIME_NS   330
`define BLANK_CYCLES    ((`BLANK_TIME_NS * `CLK_MHZ + 999) / 1000)
`define OLP_DELAY_MS    75
`define OLP_CYCLES      (`OLP_DELAY_MS * `CLK_MHZ * 1000)
`define NOM_PERIOD      12'hEA6
`define DITHER_HALF     12'h080
`define MAX_DUTY_PCT    70
`define KNEE_DUTY_PCT   36
`define MAX_ON_CYCLES   (3750 * `MAX_DUTY_PCT / 100)
`define KNEE_CYCLES     (3750 * `KNEE_DUTY_PCT / 100)

// Current limit levels in millivolts, and the dither LFSR seed
`define LIMIT_BLANK_MV  11'h69A
`define LIMIT_MAX_MV    11'h378
`define LIMIT_ZERO_MV   11'h2BC
`define LFSR_SEED       8'h01

`endif

// file: pwm_protection_sequencer_pkg.sv
package pwm_protection_sequencer_pkg;
    typedef enum logic [2:0] {
        st_off,
        st_run,
        st_burst,
        st_latched,
        st_thermal_hold,
        st_restart_wait
    } mode_t;
endpackage

// file: pwm_protection_sequencer.sv
`include "pwm_protection_sequencer_regs.svh"
// Operation
// [RULE1] Each turn-on opens a 330 ns blanking window masking feedback and normal trips.
// [RULE2] During blanking the 1.69 V limit is selected; a trip there ends the pulse.
// [RULE3] Switching period dithers pseudo-randomly around the nominal average.
// [RULE4] Feedback at stop level leaves continuous switching for burst mode.
// [RULE5] Supply at bias level while in burst enables the startup current source.
// [RULE6] Sensed current reaching the active limit ends the pulse every cycle.
// [RULE7] Limit rises linearly with on-time from zero-duty value, fixed 0.888 V past 36 %.
// [RULE8] Feedback at overload level for 75 ms stops switching; shorter excursions restart.
// [RULE9] During overload bias assist stays off so lockout restart cycles repeat.
// [RULE10] Supply at or above 29.1 V declares overvoltage.
// [RULE11] A fixed variant selection picks latched or auto-restart fault handling.
// [RULE12] Latched variant stops, latches, and keeps supply up with bias assist.
// [RULE13] The shutdown latch clears only when supply drops below the off level.
// [RULE14] Auto-restart overvoltage stops with bias off; lockout cycle restarts it.
// [RULE15] Temperature at or above 145 C declares thermal fault, handled per variant.
// [RULE16] Supply at 8.5 V off level stops everything and returns to pre-startup.
// [RULE17] Supply reaching the 15.0 V on level starts operation and switching.
// [RULE18] Auto-restart thermal keeps bias assist until cooled, then lets lockout restart.
// [RULE19] Blanking and overload delay are counted on the clock; flags are synchronised.
module pwm_protection_sequencer #(
    parameter int unsigned OLP_CYCLES = `OLP_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,

    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,

    input  wire logic        feedback_pin_trip,
    input  wire logic        current_sense_pin_trip,
    input  wire logic        feedback_stop_level,
    input  wire logic        overload_feedback_level,
    input  wire logic        supply_on_level,
    input  wire logic        supply_off_level,
    input  wire logic        bias_assist_level,
    input  wire logic        supply_overvoltage_level,
    input  wire logic        thermal_trip_temp,
    input  wire logic        latched_variant_sel,

    output logic             gate_on,
    output logic             blanking_active,
    output logic      [10:0] current_limit_mv,
    output logic             startup_current_en
);
    localparam logic [6:0]  BLANK_LOAD = 7'(`BLANK_CYCLES);
    localparam logic [11:0] MAX_ON     = 12'(`MAX_ON_CYCLES);
    localparam logic [11:0] KNEE       = 12'(`KNEE_CYCLES);
    localparam logic [11:0] SLOPE_STEP = 12'(`LIMIT_MAX_MV - `LIMIT_ZERO_MV);
    localparam logic [24:0] OLP_LAST   = 25'(OLP_CYCLES - 1);

    logic [`IN_WIDTH-1:0] sync1;
    logic [`IN_WIDTH-1:0] sync2;
    logic [`IN_WIDTH-1:0] sync3;
    logic [`IN_WIDTH-1:0] flt;

    pwm_protection_sequencer_pkg::mode_t mode;
    logic                 latched_variant;

    logic [11:0]          period_cnt;
    logic [11:0]          period_len;
    logic [11:0]          next_len;
    logic [11:0]          on_cnt;

    logic [6:0]           blank_cnt;
    logic [10:0]          comp_mv;
    logic [11:0]          slope_acc;

    logic [7:0]           lfsr;

    logic [24:0]          olp_cnt;
    logic                 olp_done;

    logic                 cyc_start;
    logic                 end_pulse;
    logic                 ocp_end;
    logic                 fault_stop;

    logic                 dither_en;

    logic [`EV_WIDTH-1:0] irq_status;
    logic [`EV_WIDTH-1:0] irq_mask;
    logic [`EV_WIDTH-1:0] ev_set;
    logic [`EV_WIDTH-1:0] ev_clr;

    logic                 wr_pend;
    logic [7:0]           wr_addr;
    logic [31:0]          rd_val;

    logic                 active;

    // Three-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1 <= '0;
            sync2 <= '0;
            sync3 <= '0;
        end else begin
            sync1 <= {latched_variant_sel, thermal_trip_temp, supply_overvoltage_level,
                      bias_assist_level, supply_off_level, supply_on_level,
                      overload_feedback_level, feedback_stop_level,
                      current_sense_pin_trip, feedback_pin_trip};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // Filtered level moves only once stages two and three agree
    for (genvar i = 0; i < `IN_WIDTH; i++) begin : g_filter
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                flt[i] <= 1'b0;
            end else if (sync2[i] == sync3[i]) begin
                flt[i] <= sync3[i]; // RULE19
            end
        end
    end

    // Variant strap sampled only in st_off, fixed while running
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            latched_variant <= 1'b0;
        end else if (mode == pwm_protection_sequencer_pkg::st_off) begin
            latched_variant <= flt[`IN_LATCH_SEL]; // RULE11
        end
    end

    assign active     = (mode == pwm_protection_sequencer_pkg::st_run) ||
                        (mode == pwm_protection_sequencer_pkg::st_burst);
    assign fault_stop = flt[`IN_OVERVOLT] || flt[`IN_HOT]; // RULE10 RULE15

    // Overload delay; any drop below the level restarts the count
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            olp_cnt <= '0;
        end else if (active && flt[`IN_OLP_HIGH] && !olp_done) begin
            olp_cnt <= olp_cnt + 25'h0000001; // RULE8
        end else begin
            olp_cnt <= '0; // RULE8
        end
    end
    assign olp_done = active && flt[`IN_OLP_HIGH] && (olp_cnt == OLP_LAST);

    // Operating mode; supply collapse overrides everything
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mode <= pwm_protection_sequencer_pkg::st_off;
        end else if (flt[`IN_SUPPLY_OFF]) begin
            mode <= pwm_protection_sequencer_pkg::st_off; // RULE16 RULE13
        end else begin
            case (mode)
                pwm_protection_sequencer_pkg::st_off: begin
                    if (flt[`IN_SUPPLY_ON]) begin
                        mode <= pwm_protection_sequencer_pkg::st_run; // RULE17
                    end
                end
                pwm_protection_sequencer_pkg::st_run,
                pwm_protection_sequencer_pkg::st_burst: begin
                    if (fault_stop && latched_variant) begin
                        mode <= pwm_protection_sequencer_pkg::st_latched; // RULE12
                    end else if (flt[`IN_HOT]) begin
                        mode <= pwm_protection_sequencer_pkg::st_thermal_hold; // RULE18
                    end else if (flt[`IN_OVERVOLT] || olp_done) begin
                        mode <= pwm_protection_sequencer_pkg::st_restart_wait; // RULE14 RULE9
                    end else if (flt[`IN_FB_STOP]) begin
                        mode <= pwm_protection_sequencer_pkg::st_burst; // RULE4
                    end else begin
                        mode <= pwm_protection_sequencer_pkg::st_run;
                    end
                end
                pwm_protection_sequencer_pkg::st_thermal_hold: begin
                    if (!flt[`IN_HOT]) begin
                        mode <= pwm_protection_sequencer_pkg::st_restart_wait; // RULE18
                    end
                end
                pwm_protection_sequencer_pkg::st_latched: begin
                    mode <= pwm_protection_sequencer_pkg::st_latched; // RULE13
                end
                pwm_protection_sequencer_pkg::st_restart_wait: begin
                    mode <= pwm_protection_sequencer_pkg::st_restart_wait;
                end
                default: begin
                    mode <= pwm_protection_sequencer_pkg::st_off;
                end
            endcase
        end
    end

    // Bias assist only where the supply must be held up; off in restart wait
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            startup_current_en <= 1'b0;
        end else begin
            startup_current_en <= flt[`IN_BIAS_LOW] && !flt[`IN_SUPPLY_OFF] &&
                ((mode == pwm_protection_sequencer_pkg::st_burst) ||         // RULE5
                 (mode == pwm_protection_sequencer_pkg::st_latched) ||       // RULE12
                 (mode == pwm_protection_sequencer_pkg::st_thermal_hold));   // RULE18 RULE9 RULE14
        end
    end

    // Period dither source
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lfsr <= `LFSR_SEED;
        end else begin
            lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
        end
    end
    assign next_len = dither_en ? 12'(`NOM_PERIOD - `DITHER_HALF + {4'h0, lfsr}) // RULE3
                                : `NOM_PERIOD;

    // Pulse end: trips pass the 3-stage synchroniser and filter, so about 16 ns is added to on-time
    assign ocp_end   = flt[`IN_OCP_TRIP]; // RULE6 RULE2
    assign end_pulse = (blank_cnt != 7'h00) ? ocp_end                            // RULE1
                       : (ocp_end || flt[`IN_FB_TRIP] || (on_cnt >= MAX_ON));
    assign cyc_start = (mode == pwm_protection_sequencer_pkg::st_run) && (period_cnt == 12'h000);

    // Switching cycle: period, gate, blanking window
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gate_on         <= 1'b0;
            blanking_active <= 1'b0;
            period_cnt      <= '0;
            period_len      <= `NOM_PERIOD;
            on_cnt          <= '0;
            blank_cnt       <= '0;
        end else if (mode != pwm_protection_sequencer_pkg::st_run) begin
            gate_on         <= 1'b0;
            blanking_active <= 1'b0;
            period_cnt      <= '0;
            blank_cnt       <= '0;
        end else if (cyc_start) begin
            gate_on         <= 1'b1;
            blanking_active <= 1'b1;
            blank_cnt       <= BLANK_LOAD; // RULE1 RULE19
            on_cnt          <= '0;
            period_cnt      <= period_len - 12'h001;
            period_len      <= next_len; // RULE3
        end else begin
            period_cnt <= period_cnt - 12'h001;
            if (blank_cnt != 7'h00) begin
                blank_cnt <= blank_cnt - 7'h01;
            end
            blanking_active <= gate_on && (blank_cnt > 7'h01);
            if (gate_on) begin
                on_cnt <= on_cnt + 12'h001;
                if (end_pulse) begin
                    gate_on         <= 1'b0; // RULE6
                    blanking_active <= 1'b0;
                end
            end
        end
    end

    // Duty compensation by stepping the limit without a divider
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            comp_mv   <= `LIMIT_ZERO_MV;
            slope_acc <= '0;
        end else if (cyc_start) begin
            comp_mv   <= `LIMIT_ZERO_MV;
            slope_acc <= '0;
        end else if (gate_on && comp_mv != `LIMIT_MAX_MV) begin
            if (slope_acc + SLOPE_STEP >= KNEE) begin
                slope_acc <= slope_acc + SLOPE_STEP - KNEE;
                comp_mv   <= comp_mv + 11'h001; // RULE7
            end else begin
                slope_acc <= slope_acc + SLOPE_STEP;
            end
        end
    end

    // Active limit presented to the sense comparator
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            current_limit_mv <= `LIMIT_ZERO_MV;
        end else if (cyc_start || (gate_on && blank_cnt > 7'h01 && !end_pulse &&
                                   mode == pwm_protection_sequencer_pkg::st_run)) begin
            current_limit_mv <= `LIMIT_BLANK_MV; // RULE2
        end else begin
            current_limit_mv <= comp_mv; // RULE7
        end
    end

    // Event sources for the sticky status
    always_comb begin
        ev_set = '0;
        ev_set[`EV_OCP]      = gate_on && end_pulse && ocp_end &&
                               (mode == pwm_protection_sequencer_pkg::st_run);
        ev_set[`EV_BURST]    = (mode == pwm_protection_sequencer_pkg::st_run) && flt[`IN_FB_STOP] &&
                               !fault_stop && !olp_done && !flt[`IN_SUPPLY_OFF];
        ev_set[`EV_OVERLOAD] = olp_done;
        ev_set[`EV_OVERVOLT] = active && flt[`IN_OVERVOLT];
        ev_set[`EV_THERMAL]  = active && flt[`IN_HOT];
        ev_set[`EV_BIAS]     = startup_current_en;
    end

    // Set wins over a same-cycle write-one clear
    assign ev_clr = (wr_pend && wr_addr == `REG_IRQ_STATUS) ? hwdata[`EV_WIDTH-1:0] : '0;
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            irq_status <= '0;
            irq        <= 1'b0;
        end else begin
            irq_status <= (irq_status & ~ev_clr) | ev_set;
            irq        <= |(irq_status & irq_mask);
        end
    end

    // Bus address phase capture; zero wait states
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_pend   <= 1'b0;
            wr_addr   <= '0;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            if (hready) begin
                wr_pend <= hsel && htrans[1] && hwrite;
                wr_addr <= haddr[7:0];
            end
        end
    end

    // Writable registers
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dither_en <= `CTRL_RESET;
            irq_mask  <= `IRQ_MASK_RESET;
        end else if (wr_pend) begin
            if (wr_addr == `REG_CTRL) begin
                dither_en <= hwdata[`CTRL_DITHER_BIT];
            end
            if (wr_addr == `REG_IRQ_MASK) begin
                irq_mask <= hwdata[`EV_WIDTH-1:0];
            end
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_val = '0;
        case (haddr[7:0])
            `REG_CTRL:       rd_val[`CTRL_DITHER_BIT] = dither_en;
            `REG_IRQ_STATUS: rd_val[`EV_WIDTH-1:0] = irq_status;
            `REG_IRQ_MASK:   rd_val[`EV_WIDTH-1:0] = irq_mask;
            `REG_STATE:      rd_val[7:0] = {latched_variant, startup_current_en,
                                            gate_on, blanking_active, 1'b0, mode};
            default:         rd_val = '0;
        endcase
    end

    // Read data registered at the address phase edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            hrdata <= '0;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            hrdata <= rd_val;
        end
    end
endmodule

// file: pwm_protection_sequencer_chk.sv
`include "pwm_protection_sequencer_regs.svh"
module pwm_protection_sequencer_chk #(
    parameter int unsigned OLP_CYCLES = 200
) (
    input wire logic        clk,
    input wire logic        resetn,
    input wire logic        gate_on,
    input wire logic        blanking_active,
    input wire logic [10:0] current_limit_mv,
    input wire logic        startup_current_en,
    input wire logic        current_sense_pin_trip,
    input wire logic        feedback_pin_trip,
    input wire logic        overload_feedback_level,
    input wire logic        supply_off_level,
    input wire logic        bias_assist_level,
    input wire logic        supply_overvoltage_level,
    input wire logic        thermal_trip_temp
);
    int unsigned blank_cnt;
    int unsigned on_cnt;
    int unsigned ol_cnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    // Run-length counters
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            blank_cnt <= 0;
            on_cnt    <= 0;
            ol_cnt    <= 0;
        end else begin
            blank_cnt <= blanking_active ? blank_cnt + 1 : 0;
            on_cnt    <= gate_on ? on_cnt + 1 : 0;
            ol_cnt    <= overload_feedback_level ? ol_cnt + 1 : 0;
        end
    end

    a_blank_turnon: assert property ($rose(gate_on) |-> blanking_active && current_limit_mv == `LIMIT_BLANK_MV)
        else $error("no blanking at turn-on");
    a_blank_length: assert property ($fell(blanking_active) && gate_on |-> blank_cnt == `BLANK_CYCLES)
        else $error("blanking length");
    a_limit_range: assert property (!blanking_active |-> current_limit_mv inside {[`LIMIT_ZERO_MV:`LIMIT_MAX_MV]})
        else $error("limit out of range");
    a_limit_knee: assert property (on_cnt > `KNEE_CYCLES + 4 && !blanking_active |-> current_limit_mv == `LIMIT_MAX_MV)
        else $error("limit not fixed");
    a_limit_ramp: assert property (gate_on && $past(gate_on) && !blanking_active && !$past(blanking_active)
        |-> current_limit_mv >= $past(current_limit_mv))
        else $error("limit fell");
    a_sense_ends: assert property (current_sense_pin_trip [*8] |-> !gate_on)
        else $error("sense trip ignored");
    a_fb_ends: assert property ((feedback_pin_trip && !blanking_active) [*8] |-> !gate_on)
        else $error("feedback trip ignored");
    a_overload_stop: assert property (ol_cnt > OLP_CYCLES + 8 |-> !gate_on && !startup_current_en)
        else $error("overload not stopped");
    a_off_no_gate: assert property (supply_off_level [*8] |-> !gate_on)
        else $error("gate on below off");
    a_fault_stop: assert property ((supply_overvoltage_level || thermal_trip_temp) [*8] |-> !gate_on)
        else $error("gate on in fault");
    a_bias_level: assert property (!bias_assist_level [*8] |-> !startup_current_en)
        else $error("bias assist too early");
endmodule

bind pwm_protection_sequencer pwm_protection_sequencer_chk #(.OLP_CYCLES(OLP_CYCLES)) chk (
    .clk, .resetn, .gate_on, .blanking_active, .current_limit_mv, .startup_current_en,
    .current_sense_pin_trip, .feedback_pin_trip, .overload_feedback_level, .supply_off_level,
    .bias_assist_level, .supply_overvoltage_level, .thermal_trip_temp
);

// file: power_stage_model.sv
module power_stage_model (
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        gate_on,
    input  wire logic [11:0] sense_after,
    input  wire logic [11:0] fb_after,
    output logic             current_sense_pin_trip,
    output logic             feedback_pin_trip
);
    int unsigned on_time;

    // Trip after a set on-time; zero never trips
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            on_time                <= 0;
            current_sense_pin_trip <= 1'b0;
            feedback_pin_trip      <= 1'b0;
        end else begin
            on_time                <= gate_on ? on_time + 1 : 0;
            current_sense_pin_trip <= gate_on && sense_after != 12'h000 && on_time >= sense_after;
            feedback_pin_trip      <= gate_on && fb_after != 12'h000 && on_time >= fb_after;
        end
    end
endmodule

// file: tb_pwm_protection_sequencer.sv
`include "pwm_protection_sequencer_regs.svh"
module tb_pwm_protection_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, hreadyout, hresp, irq, cs_trip, fb_trip, gate_on, blanking_active, bias_en, differ;
    logic        resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, rd_phase = 1'b0;
    logic        fb_stop = 1'b0, ol_high = 1'b0, sup_on = 1'b0, sup_off = 1'b1;
    logic        bias_low = 1'b0, ov = 1'b0, hot = 1'b0, lsel = 1'b0;
    logic [1:0]  htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [10:0] limit_mv;
    logic [11:0] sense_after = 12'h000, fb_after = 12'h000;
    logic [15:0] lfsr = 16'h034F;
    logic [63:0] note;
    logic [63:0] exp_q[$];
    int          failures = 0, checks = 0, w, p, p0;

    // Clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    pwm_protection_sequencer #(.OLP_CYCLES(200)) dut (
        .clk, .resetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
        .hrdata, .hreadyout, .hresp, .irq, .feedback_pin_trip(fb_trip), .current_sense_pin_trip(cs_trip),
        .feedback_stop_level(fb_stop), .overload_feedback_level(ol_high), .supply_on_level(sup_on),
        .supply_off_level(sup_off), .bias_assist_level(bias_low), .supply_overvoltage_level(ov),
        .thermal_trip_temp(hot), .latched_variant_sel(lsel), .gate_on,
        .blanking_active, .current_limit_mv(limit_mv), .startup_current_en(bias_en)
    );
    power_stage_model stage (
        .clk, .resetn, .gate_on, .sense_after, .fb_after,
        .current_sense_pin_trip(cs_trip), .feedback_pin_trip(fb_trip)
    );

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    // Single transfer, waits on hready in both phases
    task automatic bus(input logic wr, input logic [31:0] a, d, e, m);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        htrans   <= 2'h0;
        hsel     <= 1'b0;
        hwdata   <= d;
        rd_phase <= !wr;
        if (!wr) exp_q.push_back({m, e});
        do @(posedge clk); while (hreadyout !== 1'b1);
        rd_phase <= 1'b0;
    endtask

    task automatic rd(input logic [31:0] a, e, m);
        bus(1'b0, a, 32'h0, e, m);
    endtask

    task automatic wr(input logic [31:0] a, d);
        bus(1'b1, a, d, 32'h0, 32'h0);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic pulse(output int wd);
        @(posedge gate_on);
        wd = 0;
        while (gate_on === 1'b1) begin
            @(posedge clk);
            wd++;
        end
    endtask

    task automatic period(output int pd);
        realtime t0;
        @(posedge gate_on);
        t0 = $realtime;
        @(posedge gate_on);
        pd = int'(($realtime - t0) / 4.0);
    endtask

    task automatic st(input logic [7:0] e, m);
        wait_clk(12);
        rd(32'h0C, 32'(e), 32'(m));
    endtask

    // Supply below off level, then up to on level
    task automatic power_cycle(input logic latched);
        @(posedge clk);
        sup_off <= 1'b1;
        sup_on  <= 1'b0;
        lsel    <= latched;
        st(8'h0, 8'h7);
        sup_off <= 1'b0;
        sup_on  <= 1'b1;
        st(8'h1, 8'h7);
    endtask

    // Read data against oldest note
    always @(posedge clk) begin
        if (rd_phase && hreadyout === 1'b1) begin
            note = exp_q.pop_front();
            check(hrdata & note[63:32], note[31:0]);
            check(32'(hresp), 32'h0);
        end
    end

    // Hang guard
    initial begin
        wait_clk(100000);
        failures++;
        finish_test;
    end

    initial begin
        wait_clk(5);
        resetn <= 1'b1;
        rd(32'h00, 32'h1, 32'hFFFFFFFF);
        rd(32'h04, 32'h0, 32'hFFFFFFFF);
        rd(32'h08, 32'h0, 32'hFFFFFFFF);
        lfsr = lfsr_next(lfsr);
        wr(32'h10, {16'h0, lfsr});
        rd(32'h10, 32'h0, 32'hFFFFFFFF);
        power_cycle(1'b0);
        // Surge trip inside blanking ends the pulse
        sense_after <= 12'h014;
        pulse(w);
        check(32'(w < `BLANK_CYCLES), 32'h1);
        rd(32'h04, 32'h1, 32'h1);
        sense_after <= 12'h000;
        fb_after    <= 12'h00A;
        wr(32'h04, 32'h3F);
        pulse(w);
        check(32'(w >= `BLANK_CYCLES && w < `BLANK_CYCLES + 20), 32'h1);
        fb_after <= 12'h000;
        pulse(w);
        // Period fixed without dither, spread with it
        sense_after <= 12'h190;
        wr(32'h00, 32'h0);
        period(p);
        period(p);
        check(32'(p), 32'(`NOM_PERIOD));
        wr(32'h00, 32'h1);
        period(p0);
        differ = 1'b0;
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            sense_after <= 12'h064 + {3'h0, lfsr[8:0]};
            period(p);
            differ |= (p != p0);
            check(32'(p + `DITHER_HALF >= `NOM_PERIOD && p <= `NOM_PERIOD + `DITHER_HALF), 32'h1);
        end
        check(32'(differ), 32'h1);
        // Burst entry interrupt, write-one clear
        wr(32'h08, 32'h2);
        fb_stop <= 1'b1;
        st(8'h2, 8'h7);
        check(32'(irq), 32'h1);
        bias_low <= 1'b1;
        st(8'h42, 8'h47);
        wr(32'h04, 32'h2);
        wait_clk(3);
        check(32'(irq), 32'h0);
        wr(32'h08, 32'h0);
        wait_clk(3);
        check(32'(irq), 32'h0);
        fb_stop  <= 1'b0;
        bias_low <= 1'b0;
        // Short overload excursions restart
        repeat (2) begin
            ol_high <= 1'b1;
            wait_clk(150);
            ol_high <= 1'b0;
            wait_clk(5);
        end
        rd(32'h0C, 32'h1, 32'h7);
        ol_high  <= 1'b1;
        bias_low <= 1'b1;
        wait_clk(250);
        rd(32'h0C, 32'h5, 32'h47);
        ol_high  <= 1'b0;
        bias_low <= 1'b0;
        power_cycle(1'b1);
        // Latched variant holds after fault
        ov <= 1'b1;
        st(8'h3, 8'h7);
        ov       <= 1'b0;
        bias_low <= 1'b1;
        st(8'h43, 8'h47);
        bias_low <= 1'b0;
        power_cycle(1'b1);
        hot <= 1'b1;
        st(8'h3, 8'h7);
        hot <= 1'b0;
        power_cycle(1'b0);
        // Auto-restart variant
        ov       <= 1'b1;
        bias_low <= 1'b1;
        st(8'h5, 8'h47);
        ov       <= 1'b0;
        bias_low <= 1'b0;
        power_cycle(1'b0);
        hot      <= 1'b1;
        bias_low <= 1'b1;
        st(8'h44, 8'h47);
        hot <= 1'b0;
        st(8'h5, 8'h47);
        bias_low <= 1'b0;
        finish_test;
    end
endmodule
